//--- common/host_port_pkg.sv
package host_port_pkg;

	// Host link selected by the mode strap pins.
	typedef enum logic [1:0] {
		MODE_SERIAL = 2'b00,
		MODE_SEP_STROBE = 2'b01,
		MODE_DATA_STROBE = 2'b10,
		MODE_NONE = 2'b11
	} host_mode_t;

	// Parallel access sequencer states.
	typedef enum logic [1:0] {
		P_IDLE = 2'b00,
		P_SETTLE = 2'b01,
		P_WAIT_RD = 2'b10,
		P_DONE = 2'b11
	} par_state_t;

	// Every pin from the host, gathered so one synchroniser serves them all.
	typedef struct packed {
		logic [1:0] mode;
		logic shift_clk;
		logic serial_in_line;
		logic shift_edge_select;
		logic serial_sel_n;
		logic ale;
		logic rd_n;
		logic wr_n;
		logic addr_strobe_input;
		logic data_strobe_low;
		logic rw_dir;
		logic [7:0] ad;
	} host_pins_t;

	localparam int PIN_W = $bits(host_pins_t);

	// Request towards the configuration and status registers of the device.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// Answer from the register array: one-cycle valid with data.
	typedef struct packed {
		logic rvalid;
		logic [7:0] rdata;
	} reg_rsp_t;

	localparam int DATA_W = 8;
	localparam int CLK_MHZ = 250;

	// Serial frame: command byte (bit 7 set means read, bits 6:0 address), then one data byte, MSB first.
	localparam int SER_CMD_RD_BIT = 7;
	localparam logic [4:0] SER_CMD_LAST = 5'h07;
	localparam logic [4:0] SER_DATA_LAST = 5'h0F;
	localparam logic [4:0] SER_FRAME_BITS = 5'h10;
	localparam logic [3:0] SER_OUT_BITS = 4'h8;

	// Write data on the parallel bus is taken after it has settled behind the synchroniser.
	localparam int WR_SETTLE_NS = 8;
	localparam int WR_SETTLE_CYC_I = (WR_SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0] WR_SETTLE_CYC = 4'(WR_SETTLE_CYC_I < 1 ? 1 : WR_SETTLE_CYC_I);

	localparam logic [7:0] AD_RESET = 8'h00;
	localparam logic [3:0] CNT_ZERO = 4'h0;

endpackage

//--- rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
	import host_port_pkg::*;
(
	input wire logic sys_clk, // system clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic [PIN_W-1:0] pins_in, // raw host pins
	output logic [PIN_W-1:0] pins_now, // synchronised level
	output logic [PIN_W-1:0] pins_prev // synchronised level one cycle earlier
);

	genvar i;
	generate
		for (i = 0; i < PIN_W; i++) begin : g_bit
			logic meta_q;
			logic sync_q;
			logic prev_q;
			// Only the second stage reads the first; edge logic looks at the later two.
			always_ff @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
					prev_q <= 1'b0;
				end else begin
					meta_q <= pins_in[i];
					sync_q <= meta_q;
					prev_q <= sync_q;
				end
			end
			assign pins_now[i] = sync_q;
			assign pins_prev[i] = prev_q;
		end
	endgenerate

endmodule // pin_sync

//--- rtl/host_control_port.sv
`timescale 1ns/1ps
// Behaviour
// - serial mode shifts register bits out serially
// - edge select high falling, low rising edge
// - data-strobe read: acknowledge low with valid data
// - data-strobe write: acknowledge low when data accepted
// - separate-strobe: ready low while access in progress
// - separate-strobe: ready high when access completes
// - separate-strobe: drive read data while read low
// - data-strobe, direction 0: capture write data
// - data-strobe, direction 1: drive read data
// - eight shared lines, address then data, MSB bit7
// - serial input sampled on shift-clock rising edge
// - address latched on latch-enable falling edge
// - address latched on address-strobe falling edge
module host_control_port
	import host_port_pkg::*;
(
	input wire logic sys_clk, // system clock, 250 MHz
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic [1:0] host_mode, // link select strap, see host_mode_t
	input wire logic shift_clk, // serial shift clock from host
	input wire logic serial_in_line, // serial data from host
	input wire logic serial_sel_n, // serial frame select, active low
	input wire logic shift_edge_select, // serial output edge select
	output logic serial_out_line, // serial data to host
	input wire logic ale, // address latch enable, separate-strobe mode
	input wire logic rd_n, // read strobe, active low
	input wire logic wr_n, // write strobe, active low
	output logic rdy, // ready, low while a separate-strobe access is in progress
	input wire logic addr_strobe_input, // address strobe, data-strobe mode
	input wire logic data_strobe_low, // data strobe, active low
	input wire logic rw_dir, // direction, 1 read, 0 write
	output logic ack_n, // acknowledge, active low
	input wire logic [7:0] ad_in, // multiplexed bus, level seen at pins
	output logic [7:0] ad_out, // multiplexed bus, value driven
	output logic ad_oe, // multiplexed bus output enable, high drives
	output reg_req_t reg_req, // register access request, one-cycle strobes
	input wire reg_rsp_t reg_rsp // register read answer
);

	host_pins_t raw_pins;
	host_pins_t pin_now;
	host_pins_t pin_prev;
	host_mode_t mode;

	assign raw_pins = '{mode: host_mode, shift_clk: shift_clk, serial_in_line: serial_in_line,
		shift_edge_select: shift_edge_select, serial_sel_n: serial_sel_n, ale: ale, rd_n: rd_n,
		wr_n: wr_n, addr_strobe_input: addr_strobe_input, data_strobe_low: data_strobe_low,
		rw_dir: rw_dir, ad: ad_in};

	pin_sync u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.pins_in(raw_pins),
		.pins_now(pin_now),
		.pins_prev(pin_prev)
	);

	assign mode = host_mode_t'(pin_now.mode);

	// Serial link.
	logic ser_on;
	logic sclk_rise;
	logic sclk_fall;
	logic out_edge;
	logic [4:0] bit_cnt_q;
	logic [7:0] in_sh_q;
	logic [7:0] in_next;
	logic cmd_rd_q;
	logic [6:0] cmd_addr_q;
	logic [7:0] out_sh_q;
	logic [3:0] out_cnt_q;
	logic sdo_q;
	logic ser_rd;
	logic ser_wr;

	assign ser_on = (mode == MODE_SERIAL) && !pin_now.serial_sel_n;
	assign sclk_rise = pin_now.shift_clk && !pin_prev.shift_clk;
	assign sclk_fall = !pin_now.shift_clk && pin_prev.shift_clk;
	assign out_edge = pin_now.shift_edge_select ? sclk_fall : sclk_rise;
	assign in_next = {in_sh_q[6:0], pin_now.serial_in_line};
	assign ser_rd = ser_on && sclk_rise && (bit_cnt_q == SER_CMD_LAST) && in_next[SER_CMD_RD_BIT];
	assign ser_wr = ser_on && sclk_rise && (bit_cnt_q == SER_DATA_LAST) && !cmd_rd_q;

	// Input bits are taken on the rising edge of the shift clock.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt_q <= 5'h00;
			in_sh_q <= AD_RESET;
		end else if (!ser_on) begin
			bit_cnt_q <= 5'h00;
		end else if (sclk_rise && bit_cnt_q != SER_FRAME_BITS) begin
			in_sh_q <= in_next;
			bit_cnt_q <= bit_cnt_q + 5'h01;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_rd_q <= 1'b0;
			cmd_addr_q <= 7'h00;
		end else if (!ser_on) begin
			cmd_rd_q <= 1'b0;
		end else if (sclk_rise && bit_cnt_q == SER_CMD_LAST) begin
			cmd_rd_q <= in_next[SER_CMD_RD_BIT];
			cmd_addr_q <= in_next[6:0];
		end
	end

	// The read answer must arrive within half a shift-clock period of the last command bit.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_sh_q <= AD_RESET;
			out_cnt_q <= CNT_ZERO;
			sdo_q <= 1'b0;
		end else if (!ser_on) begin
			out_cnt_q <= CNT_ZERO;
		end else if (reg_rsp.rvalid && cmd_rd_q) begin
			out_sh_q <= reg_rsp.rdata;
		end else if (out_edge && cmd_rd_q && bit_cnt_q >= 5'h08 && out_cnt_q != SER_OUT_BITS) begin
			// The bit changes on the selected edge so the host can sample it on the other one.
			sdo_q <= out_sh_q[7];
			out_sh_q <= {out_sh_q[6:0], 1'b0};
			out_cnt_q <= out_cnt_q + 4'h1;
		end
	end

	assign serial_out_line = sdo_q;

	// Parallel links share one sequencer; only the strobe, direction and address-latch decode and the ready/acknowledge output differ.
	logic sep_on;
	logic ds_on;
	logic par_on;
	logic strobe_now;
	logic strobe_prev;
	logic strobe_fall;
	logic strobe_rise;
	logic want_read;
	logic addr_edge;
	par_state_t pst_q;
	logic [7:0] par_addr_q;
	logic [7:0] par_wdata_q;
	logic par_is_rd_q;
	logic [3:0] settle_q;
	logic [7:0] ad_out_q;
	logic ad_oe_q;
	logic par_rd;
	logic par_wr;

	assign sep_on = (mode == MODE_SEP_STROBE);
	assign ds_on = (mode == MODE_DATA_STROBE);
	assign par_on = sep_on || ds_on;
	assign strobe_now = sep_on ? (!pin_now.rd_n || !pin_now.wr_n) : !pin_now.data_strobe_low;
	assign strobe_prev = sep_on ? (!pin_prev.rd_n || !pin_prev.wr_n) : !pin_prev.data_strobe_low;
	assign strobe_fall = par_on && strobe_now && !strobe_prev;
	assign strobe_rise = !strobe_now && strobe_prev;
	assign want_read = sep_on ? !pin_now.rd_n : pin_now.rw_dir;
	assign addr_edge = sep_on ? (!pin_now.ale && pin_prev.ale)
		: (ds_on && !pin_now.addr_strobe_input && pin_prev.addr_strobe_input);

	// The bus carries the address first, bit 7 most significant.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			par_addr_q <= AD_RESET;
		end else if (addr_edge) begin
			par_addr_q <= pin_prev.ad;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pst_q <= P_IDLE;
			par_is_rd_q <= 1'b0;
			settle_q <= CNT_ZERO;
			par_wdata_q <= AD_RESET;
		end else if (!par_on || (strobe_rise && pst_q != P_IDLE)) begin
			pst_q <= P_IDLE;
		end else begin
			unique case (pst_q)
				P_IDLE: begin
					if (strobe_fall) begin
						par_is_rd_q <= want_read;
						settle_q <= CNT_ZERO;
						pst_q <= want_read ? P_WAIT_RD : P_SETTLE;
					end
				end
				P_SETTLE: begin
					if (settle_q == WR_SETTLE_CYC) begin
						par_wdata_q <= pin_now.ad;
						pst_q <= P_DONE;
					end else begin
						settle_q <= settle_q + 4'h1;
					end
				end
				P_WAIT_RD: begin
					if (reg_rsp.rvalid) begin
						pst_q <= P_DONE;
					end
				end
				P_DONE: begin
					pst_q <= P_DONE;
				end
			endcase
		end
	end

	assign par_rd = (pst_q == P_IDLE) && strobe_fall && want_read;
	assign par_wr = (pst_q == P_SETTLE) && (settle_q == WR_SETTLE_CYC) && !strobe_rise;

	// Drivers turn on only once read data is held and drop with the end of the strobe.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ad_out_q <= AD_RESET;
			ad_oe_q <= 1'b0;
		end else if (pst_q == P_WAIT_RD && reg_rsp.rvalid && par_on && !strobe_rise) begin
			ad_out_q <= reg_rsp.rdata;
			ad_oe_q <= 1'b1;
		end else if (!par_on || strobe_rise || pst_q != P_DONE) begin
			ad_oe_q <= 1'b0;
		end
	end

	assign ad_out = ad_out_q;
	assign ad_oe = ad_oe_q;
	assign rdy = !(sep_on && (pst_q == P_SETTLE || pst_q == P_WAIT_RD));
	assign ack_n = !(ds_on && pst_q == P_DONE);

	// Requests towards the registers: only one link is active at a time.
	always_comb begin
		reg_req = '0;
		if (ser_on) begin
			reg_req.rd = ser_rd;
			reg_req.wr = ser_wr;
			reg_req.addr = ser_rd ? {1'b0, in_next[6:0]} : {1'b0, cmd_addr_q};
			reg_req.wdata = in_next;
		end else if (par_on) begin
			reg_req.rd = par_rd;
			reg_req.wr = par_wr;
			reg_req.addr = par_addr_q;
			reg_req.wdata = pin_now.ad;
		end
	end

	logic unused_wdata;
	assign unused_wdata = ^par_wdata_q;

endmodule // host_control_port

//--- testbench/host_port_props.sv
`timescale 1ns/1ps
module host_port_props
	import host_port_pkg::*;
(
	input wire logic sys_clk, // system clock
	input wire logic rst_n, // reset, active low
	input wire logic [1:0] host_mode, // link select strap
	input wire logic rw_dir, // direction pin
	input wire logic rdy, // ready output
	input wire logic ack_n, // acknowledge output
	input wire logic ad_oe, // bus output enable
	input wire reg_req_t reg_req, // register request
	input wire reg_rsp_t reg_rsp // register answer
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	chk_oe_after_data: assert property ($rose(ad_oe) |-> $past(reg_rsp.rvalid))
		else $error("bus driven without fresh read data");
	chk_rdy_with_data: assert property ($rose(ad_oe) && host_mode == 2'b01 |-> rdy)
		else $error("read data out but ready low");
	chk_rdy_only_sep: assert property (!rdy |-> host_mode == 2'b01)
		else $error("ready low outside separate strobe mode");
	chk_rd_holds_rdy: assert property (reg_req.rd && host_mode == 2'b01 |-> ##[0:1] !rdy)
		else $error("ready not low during read");
	// A read request is raised one cycle before ready falls, so the read case is screened out through $past.
	chk_wr_settle_done: assert property ($fell(rdy) && !$past(reg_req.rd) |-> ##[1:4] reg_req.wr)
		else $error("write not completed after ready fell");
	chk_ack_only_ds: assert property (!ack_n |-> host_mode == 2'b10)
		else $error("acknowledge low outside data strobe mode");
	chk_ack_read_data: assert property ($fell(ack_n) && rw_dir |-> ad_oe)
		else $error("read acknowledged without data on bus");
	chk_ack_after_wr: assert property (reg_req.wr && host_mode == 2'b10 |-> ##[0:2] !ack_n)
		else $error("write accepted without acknowledge");
	chk_no_drive_wr: assert property (reg_req.wr |-> !ad_oe)
		else $error("bus driven during write");
endmodule // host_port_props

bind host_control_port host_port_props host_port_props_i (.sys_clk(sys_clk), .rst_n(rst_n),
	.host_mode(host_mode), .rw_dir(rw_dir), .rdy(rdy), .ack_n(ack_n), .ad_oe(ad_oe),
	.reg_req(reg_req), .reg_rsp(reg_rsp));

//--- testbench/reg_model.sv
`timescale 1ns/1ps
module reg_model
	import host_port_pkg::*;
(
	input wire logic sys_clk, // system clock
	input wire logic rst_n, // reset, active low
	input wire reg_req_t reg_req, // request from the port
	output reg_rsp_t reg_rsp // read answer
);
	logic [7:0] mem_q [256];
	always_ff @(posedge sys_clk) begin
		if (reg_req.wr)
			mem_q[reg_req.addr] <= reg_req.wdata;
	end
	// Answer a cycle late so the port's wait path is used; idle data toggles so stale data cannot pass.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rsp <= '0;
		end else begin
			reg_rsp.rvalid <= reg_req.rd;
			reg_rsp.rdata <= reg_req.rd ? mem_q[reg_req.addr] : ~reg_rsp.rdata;
		end
	end
endmodule // reg_model

//--- testbench/host_control_port_tb.sv
`timescale 1ns/1ps
module host_control_port_tb;
	import host_port_pkg::*;
	logic sys_clk = 0, rst_n = 0, shift_clk = 0, sin = 0, sel_n = 1, es = 0, ale = 0, rd_n = 1, wr_n = 1;
	logic as_in = 0, ds_n = 1, dir = 0, sout, rdy, ack_n, ad_oe;
	logic [1:0] mode = 2'b00;
	logic [7:0] ad = 8'h00, ad_out, bus, shadow [256];
	reg_req_t req;
	reg_rsp_t rsp;
	int err_count = 0, comparisons = 0, seed = 8742;
	always #2 sys_clk = ~sys_clk;
	// The host lets go of the bus during reads, so the pins show the device's drive.
	assign bus = ad_oe ? ad_out : ad;
	host_control_port host_control_port_i (.sys_clk(sys_clk), .rst_n(rst_n), .host_mode(mode),
		.shift_clk(shift_clk), .serial_in_line(sin), .serial_sel_n(sel_n), .shift_edge_select(es),
		.serial_out_line(sout), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .rdy(rdy),
		.addr_strobe_input(as_in), .data_strobe_low(ds_n), .rw_dir(dir), .ack_n(ack_n),
		.ad_in(bus), .ad_out(ad_out), .ad_oe(ad_oe), .reg_req(req), .reg_rsp(rsp));
	reg_model reg_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .reg_req(req), .reg_rsp(rsp));
	task automatic check(input logic [7:0] seen, input logic [7:0] expd);
		comparisons++;
		if (seen !== expd) begin
			err_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, expd);
		end
	endtask
	task automatic conclude();
		if (err_count == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// One frame of 17 shift periods; the spare period lets the last read bit be sampled.
	task automatic ser(input logic rd, input logic [6:0] a, input logic [7:0] d, output logic [7:0] got);
		logic [15:0] bits;
		bits = {rd, a, d};
		got = 8'h00;
		mode <= 2'b00;
		tick(6);
		sel_n <= 1'b0;
		for (int i = 0; i < 17; i++) begin
			tick(8);
			if (!es && i >= 9) got = {got[6:0], sout};
			shift_clk <= 1'b0;
			sin <= bits[15];
			bits = bits << 1;
			tick(8);
			if (es && i >= 8 && i < 16) got = {got[6:0], sout};
			shift_clk <= 1'b1;
		end
		tick(8);
		shift_clk <= 1'b0;
		sel_n <= 1'b1;
		tick(8);
	endtask
	task automatic par(input logic ds, input logic rd, input logic [7:0] a, input logic [7:0] d);
		int n;
		logic low;
		mode <= ds ? 2'b10 : 2'b01;
		ad <= a;
		ale <= !ds;
		as_in <= ds;
		tick(6);
		ale <= 1'b0;
		as_in <= 1'b0;
		tick(4);
		dir <= rd;
		ad <= rd ? ~a : d;
		tick(1);
		ds_n <= !ds;
		rd_n <= !(rd && !ds);
		wr_n <= !(!rd && !ds);
		low = 1'b0;
		n = 0;
		tick(1);
		while ((ds ? ack_n : !(low && rdy)) && n < 40) begin
			low = low | !rdy;
			n++;
			tick(1);
		end
		check({7'h00, n < 40}, 8'h01);
		if (rd) begin
			check({7'h00, ad_oe}, 8'h01);
			check(ad_out, shadow[a]);
		end else begin
			shadow[a] = d;
		end
		ds_n <= 1'b1;
		rd_n <= 1'b1;
		wr_n <= 1'b1;
		tick(8);
		check({6'h00, ad_oe, ack_n}, 8'h01);
	endtask
	initial begin
		logic [7:0] a, d, got;
		tick(10);
		rst_n <= 1'b1;
		tick(4);
		for (int k = 0; k < 8; k++) begin
			a = 8'($random(seed)) & 8'h7F;
			d = 8'($random(seed));
			if (k == 0) begin
				a = 8'h7F;
				d = 8'h80;
			end
			es <= k[1];
			ser(1'b0, a[6:0], d, got);
			shadow[a] = d;
			ser(1'b1, a[6:0], 8'h00, got);
			check(got, shadow[a]);
			par(k[0], 1'b1, a, 8'h00);
			par(k[0], 1'b0, a | 8'h80, ~d);
			par(!k[0], 1'b1, a | 8'h80, 8'h00);
		end
		conclude();
	end
	initial begin
		tick(60000);
		err_count++;
		conclude();
	end
endmodule // host_control_port_tb
